// ==== usa_cfg.svh ====
// usa_cfg.svh: register offsets, field positions, reset values and timing counts
// assumes: included by bare name from the package and the modules of the serial port
`ifndef USA_CFG_SVH
`define USA_CFG_SVH

// byte offsets on the register bus
`define USA_OFS_CTRL      4'h0
`define USA_OFS_STAT      4'h4
`define USA_OFS_RXD       4'h8
`define USA_OFS_TXD       4'hC

// control register fields
`define USA_CTRL_W        18
`define USA_CTRL_RST      18'h00000
`define USA_F_MODE        0
`define USA_F_LEN7        2
`define USA_F_STOP2       3
`define USA_F_PAREN       4
`define USA_F_PARODD      5
`define USA_F_RXEN        6
`define USA_F_TXEN        7
`define USA_F_BAUD        8
`define USA_F_AD          11
`define USA_F_CSRC        12
`define USA_F_RXIE        14
`define USA_F_TXIE        15
`define USA_F_RXIOS       16
`define USA_F_TXIOS       17

// status register fields
`define USA_S_RXV         0
`define USA_S_TXE         1
`define USA_S_PE          2
`define USA_S_ORE         3
`define USA_S_FRE         4
`define USA_S_RXBUSY      5
`define USA_S_TXBUSY      6

// operating modes and bit clock sources
`define USA_MODE_ASYNC    2'h0
`define USA_MODE_MPROC    2'h1
`define USA_MODE_SYNC     2'h2
`define USA_CSRC_INT      2'h0
`define USA_CSRC_EXT      2'h1
`define USA_CSRC_TMR      2'h2

// bit timing: sixteen sample ticks per bit
`define USA_BAUD_BASE     16'h000A
`define USA_TICK_LAST     4'hF
`define USA_TICK_RISE     4'h8
`define USA_TICK_CENTRE   4'h7
`define USA_SYNC_LAST     4'h7

`endif

// ==== usa_pkg.sv ====
// usa_pkg.sv: types shared by the serial port modules
// assumes: usa_cfg.svh on the include path
package usa_pkg;
    `include "usa_cfg.svh"

    // receiver sequencer, one-hot
    typedef enum logic [2:0] {
        USA_RX_IDLE  = 3'b001,
        USA_RX_START = 3'b010,
        USA_RX_DATA  = 3'b100
    } usa_rx_st_t;

    typedef logic [1:0] usa_mode_t;
endpackage : usa_pkg

// ==== usa_buf_if.sv ====
// usa_buf_if.sv: fill and drain sides of the receive buffer
// assumes: one clock domain shared by both sides
`timescale 1ns/100ps
interface usa_buf_if #(parameter int W = 9);
    logic         in_valid;
    logic         in_ready;
    logic [W-1:0] in_data;
    logic         out_valid;
    logic         out_ready;
    logic [W-1:0] out_data;

    modport buffer (input in_valid, in_data, out_ready,
                    output in_ready, out_valid, out_data);
    modport user   (output in_valid, in_data, out_ready,
                    input in_ready, out_valid, out_data);
endinterface : usa_buf_if

// ==== usa_buf2.sv ====
// usa_buf2.sv: two-entry buffer with valid and ready on both sides
// assumes: pushes are refused while full, the filler sees in_ready low
`timescale 1ns/100ps
module usa_buf2 #(
    parameter int W = 9
) (
    // clock and reset
    input  wire logic  I_MCLK,
    input  wire logic  I_SYS_RST,
    // buffer sides
    usa_buf_if.buffer  bif
);
    import usa_pkg::*;

    typedef struct packed {
        logic [W-1:0] head;
        logic [W-1:0] tail;
        logic [1:0]   cnt;
    } usa_buf_t;

    usa_buf_t b_reg;
    usa_buf_t b_next;
    logic     push;
    logic     pop;

    // honest flags straight from the fill count
    assign bif.in_ready  = (b_reg.cnt != 2'h2);
    assign bif.out_valid = (b_reg.cnt != 2'h0);
    assign bif.out_data  = b_reg.head;
    assign push          = bif.in_valid & bif.in_ready;
    assign pop           = bif.out_ready & bif.out_valid;

    // head always holds the oldest word
    always_comb
    begin
        b_next = b_reg;
        if (pop)
        begin
            b_next.head = b_reg.tail;
        end
        if (push)
        begin
            if (b_reg.cnt == 2'h0 || (b_reg.cnt == 2'h1 && pop))
                b_next.head = bif.in_data;
            else
                b_next.tail = bif.in_data;
        end
        b_next.cnt = b_reg.cnt + {1'b0, push} - {1'b0, pop};
    end

    always_ff @(posedge I_MCLK or posedge I_SYS_RST)
    begin
        if (I_SYS_RST)
            b_reg <= '0;
        else
            b_reg <= b_next;
    end
endmodule : usa_buf2

// ==== usa_top.sv ====
// usa_top.sv: serial port with start-stop, multi-processor and clocked framing
// assumes: Avalon-MM slave on I_MCLK; line pins are asynchronous and synchronised here
// Overview of operation
// (RULE1) full duplex, clocked and start-stop framings
// (RULE2) mode field: 0 normal, 1 multi-processor, 2 clocked
// (RULE3) clocked mode: eight bits, no framing bits
// (RULE4) seven-bit length only in normal mode
// (RULE5) one or two stop bits; receiver checks first
// (RULE6) multi-processor: 8 data plus control bit 11
// (RULE7) multi-processor acts as master only
// (RULE8) eight internal baud rate settings
// (RULE9) bit clock from external pin or timer 0
// (RULE10) NRZ line, level constant per bit
// (RULE11) framing and overrun always; parity not multi-processor
// (RULE12) receive request on data or error; transmit request
// (RULE13) requests may start the transfer service instead
// (RULE14) least significant bit first everywhere
// (RULE15) start edge found, bits sampled at centre
`timescale 1ns/100ps
`include "usa_cfg.svh"
module usa_top (
    // clock and reset
    input  wire logic        I_MCLK,
    input  wire logic        I_SYS_RST,
    // avalon-mm slave
    input  wire logic [3:0]  I_AVS_ADDRESS,
    input  wire logic        I_AVS_READ,
    input  wire logic        I_AVS_WRITE,
    input  wire logic [31:0] I_AVS_WRITEDATA,
    output logic      [31:0] O_AVS_READDATA,
    output logic             O_AVS_WAITREQUEST,
    // serial line
    input  wire logic        I_SIN,
    output logic             O_SOUT,
    input  wire logic        I_SCK,
    output logic             O_SCK,
    output logic             O_SCK_OE,
    input  wire logic        I_TMR0_OUT,
    // requests
    output logic             O_RX_IRQ,
    output logic             O_TX_IRQ,
    output logic             O_RX_IOS_REQ,
    output logic             O_TX_IOS_REQ
);
    import usa_pkg::*;

    typedef struct packed {
        logic [`USA_CTRL_W-1:0] ctrl;
        logic                   waitrq;
        logic [31:0]            rdata;
        logic [2:0]             sin_s;
        logic [2:0]             sck_s;
        logic [2:0]             tmr_s;
        logic [15:0]            baud_cnt;
        logic [8:0]             tx_hold;
        logic                   tx_hold_v;
        logic [11:0]            tx_sh;
        logic [3:0]             tx_left;
        logic [3:0]             tx_cnt;
        logic                   tx_busy;
        logic                   sout;
        logic                   sck;
        logic                   sck_oe;
        usa_rx_st_t             rx_st;
        logic [9:0]             rx_sh;
        logic [3:0]             rx_left;
        logic [3:0]             rx_cnt;
        logic                   pe;
        logic                   ore;
        logic                   fre;
        logic                   rx_irq;
        logic                   tx_irq;
        logic                   rx_ios;
        logic                   tx_ios;
    } usa_state_t;

    usa_state_t  r_reg;
    usa_state_t  r_next;
    usa_buf_if #(.W(9)) rxq ();

    // receive buffer keeps two words; a third arriving while both wait is lost as an overrun
    usa_buf2 #(.W(9)) u_rxbuf (
        .I_MCLK    (I_MCLK),
        .I_SYS_RST (I_SYS_RST),
        .bif       (rxq)
    );

    // control fields
    usa_mode_t   mode;
    logic        md_sync;
    logic        nd7;
    logic        has_x;
    logic [1:0]  csrc;
    logic        ext_sync;
    logic [15:0] baud_div;
    logic        tick;
    logic        ev_mid;
    logic        ev_edge;
    logic        sin;
    logic        acc;
    logic [11:0] frame;
    logic [3:0]  frame_len;
    logic [9:0]  rx_al;
    logic [7:0]  rx_d;
    logic        rx_x;
    logic        rx_req;
    logic        push_v;
    logic [8:0]  push_d;
    logic        pop_r;

    assign mode     = r_reg.ctrl[`USA_F_MODE +: 2];
    assign md_sync  = (mode == `USA_MODE_SYNC);                       // RULE2
    assign nd7      = r_reg.ctrl[`USA_F_LEN7] && mode == `USA_MODE_ASYNC; // RULE4
    assign has_x    = (mode == `USA_MODE_MPROC)
                      || (mode == `USA_MODE_ASYNC && r_reg.ctrl[`USA_F_PAREN]);
    assign csrc     = r_reg.ctrl[`USA_F_CSRC +: 2];
    assign ext_sync = md_sync && csrc == `USA_CSRC_EXT;
    assign sin      = r_reg.sin_s[1];
    assign acc      = (I_AVS_READ | I_AVS_WRITE) & ~r_reg.waitrq;
    assign baud_div = `USA_BAUD_BASE << r_reg.ctrl[`USA_F_BAUD +: 3];   // RULE8

    // sample tick source; external sources count their rising edges
    always_comb
    begin
        unique case (csrc)
            `USA_CSRC_EXT: tick = r_reg.sck_s[1] & ~r_reg.sck_s[2];    // RULE9
            `USA_CSRC_TMR: tick = r_reg.tmr_s[1] & ~r_reg.tmr_s[2];    // RULE9
            default:       tick = (r_reg.baud_cnt == 16'h0000);
        endcase
    end

    // clocked-mode shift events: pin edges as slave, own counter as master
    always_comb
    begin
        if (ext_sync)
        begin
            ev_mid  = r_reg.sck_s[1] & ~r_reg.sck_s[2];
            ev_edge = ~r_reg.sck_s[1] & r_reg.sck_s[2];
        end
        else
        begin
            ev_mid  = tick & r_reg.tx_busy & (r_reg.tx_cnt == `USA_TICK_RISE);
            ev_edge = tick & r_reg.tx_busy & (r_reg.tx_cnt == 4'h0);
        end
    end

    // start-stop frame built lsb first: start, data, parity or address bit, stops
    always_comb
    begin
        logic [7:0] d;
        logic       xb;
        d  = nd7 ? {1'b0, r_reg.tx_hold[6:0]} : r_reg.tx_hold[7:0];
        xb = (mode == `USA_MODE_MPROC) ? r_reg.ctrl[`USA_F_AD]             // RULE6
                                       : (^d ^ r_reg.ctrl[`USA_F_PARODD]);
        frame = 12'hFFF << (nd7 ? 4'h8 : 4'h9);                          // RULE14
        if (has_x)
        begin
            frame = (frame << 1) | ({11'h000, xb} << (nd7 ? 4'h8 : 4'h9));
        end
        frame = frame | {3'h0, d, 1'b0};
        frame_len = (nd7 ? 4'h9 : 4'hA) + {3'h0, has_x}
                    + {3'h0, mode == `USA_MODE_ASYNC && r_reg.ctrl[`USA_F_STOP2]}; // RULE5
    end

    // received bits aligned down; top holds the stop bit just sampled
    always_comb
    begin
        logic [9:0] sh;
        sh    = {sin, r_reg.rx_sh[9:1]};
        rx_al = sh >> (4'hA - ((nd7 ? 4'h8 : 4'h9) + {3'h0, has_x}));
        rx_d  = nd7 ? {1'b0, rx_al[6:0]} : rx_al[7:0];
        rx_x  = nd7 ? rx_al[7] : rx_al[8];
    end

    assign rx_req = rxq.out_valid | r_reg.pe | r_reg.ore | r_reg.fre;
    assign pop_r  = acc & I_AVS_READ & (I_AVS_ADDRESS == `USA_OFS_RXD);
    assign rxq.in_valid  = push_v;
    assign rxq.in_data   = push_d;
    assign rxq.out_ready = pop_r;

    // whole next state
    always_comb
    begin
        r_next = r_reg;
        push_v = 1'b0;
        push_d = 9'h000;
        r_next.sin_s = {r_reg.sin_s[1:0], I_SIN};
        r_next.sck_s = {r_reg.sck_s[1:0], I_SCK};
        r_next.tmr_s = {r_reg.tmr_s[1:0], I_TMR0_OUT};
        r_next.baud_cnt = (r_reg.baud_cnt == 16'h0000) ? baud_div - 16'h0001
                                                       : r_reg.baud_cnt - 16'h0001;
        // bus: one wait cycle, longer while a data word waits for the holding reg
        r_next.waitrq = ~((I_AVS_READ | I_AVS_WRITE) & r_reg.waitrq
                          & ~(I_AVS_WRITE & I_AVS_ADDRESS == `USA_OFS_TXD
                              & r_reg.tx_hold_v));
        unique case (I_AVS_ADDRESS)
            `USA_OFS_CTRL: r_next.rdata = {14'h0000, r_reg.ctrl};
            `USA_OFS_STAT: r_next.rdata = {25'h0000000, r_reg.tx_busy,
                                           r_reg.rx_st != USA_RX_IDLE, r_reg.fre,
                                           r_reg.ore, r_reg.pe, ~r_reg.tx_hold_v,
                                           rxq.out_valid};
            `USA_OFS_RXD:  r_next.rdata = {23'h000000, rxq.out_data};
            default:       r_next.rdata = 32'h00000000;
        endcase
        if (acc & I_AVS_WRITE)
        begin
            unique case (I_AVS_ADDRESS)
                `USA_OFS_CTRL: r_next.ctrl = I_AVS_WRITEDATA[`USA_CTRL_W-1:0];
                `USA_OFS_STAT:
                begin
                    // write one clears; a same-cycle error set below still wins
                    r_next.pe  = r_reg.pe  & ~I_AVS_WRITEDATA[`USA_S_PE];
                    r_next.ore = r_reg.ore & ~I_AVS_WRITEDATA[`USA_S_ORE];
                    r_next.fre = r_reg.fre & ~I_AVS_WRITEDATA[`USA_S_FRE];
                end
                `USA_OFS_TXD:
                begin
                    r_next.tx_hold   = I_AVS_WRITEDATA[8:0];
                    r_next.tx_hold_v = 1'b1;
                end
                default: r_next.ctrl = r_reg.ctrl;
            endcase
        end
        // transmitter: holding register feeds the shifter (double buffer)
        if (r_reg.tx_busy && tick)
            r_next.tx_cnt = r_reg.tx_cnt + 4'h1;
        if (!r_reg.tx_busy)
        begin
            if (r_reg.tx_hold_v && r_reg.ctrl[`USA_F_TXEN])                 // RULE1
            begin
                r_next.tx_busy   = 1'b1;
                r_next.tx_hold_v = 1'b0;
                r_next.tx_cnt    = 4'h0;
                if (md_sync)
                begin
                    r_next.tx_sh   = {4'hF, r_reg.tx_hold[7:0]};            // RULE3
                    r_next.tx_left = 4'h8;
                    r_next.sout    = r_reg.tx_hold[0];
                end
                else
                begin
                    r_next.tx_sh   = frame;
                    r_next.tx_left = frame_len;
                    r_next.sout    = frame[0];                              // RULE10
                end
            end
        end
        else if (md_sync)
        begin
            if (ev_edge)
                r_next.sck = ext_sync;
            if (ev_edge && r_reg.tx_left != 4'h8)
            begin
                r_next.tx_sh = {1'b1, r_reg.tx_sh[11:1]};                   // RULE14
                r_next.sout  = r_reg.tx_sh[1];
            end
            if (ev_mid)
            begin
                r_next.sck     = 1'b1;
                r_next.tx_left = r_reg.tx_left - 4'h1;
                r_next.tx_busy = (r_reg.tx_left != 4'h1);
            end
        end
        else if (tick && r_reg.tx_cnt == `USA_TICK_LAST)
        begin
            // bit ends only after sixteen ticks: level stays whole bit time
            r_next.tx_left = r_reg.tx_left - 4'h1;                          // RULE10
            r_next.tx_sh   = {1'b1, r_reg.tx_sh[11:1]};
            r_next.sout    = (r_reg.tx_left == 4'h1) ? 1'b1 : r_reg.tx_sh[1];
            r_next.tx_busy = (r_reg.tx_left != 4'h1);
        end
        r_next.sck_oe = md_sync & ~ext_sync;
        // receiver
        if (!r_reg.ctrl[`USA_F_RXEN])
        begin
            r_next.rx_st   = USA_RX_IDLE;
            r_next.rx_left = 4'h0;
        end
        else if (md_sync)
        begin
            r_next.rx_st = USA_RX_IDLE;
            if (ev_mid)
            begin
                r_next.rx_sh   = {sin, r_reg.rx_sh[9:1]};                   // RULE14
                r_next.rx_left = r_reg.rx_left + 4'h1;
                if (r_reg.rx_left == `USA_SYNC_LAST)                        // RULE3
                begin
                    r_next.rx_left = 4'h0;
                    push_v = 1'b1;
                    push_d = {1'b0, sin, r_reg.rx_sh[9:3]};
                end
            end
        end
        else
        begin
            if (tick)
                r_next.rx_cnt = r_reg.rx_cnt + 4'h1;
            unique case (r_reg.rx_st)
                USA_RX_IDLE:
                begin
                    if (!sin && r_reg.sin_s[2])                             // RULE15
                    begin
                        r_next.rx_st  = USA_RX_START;
                        r_next.rx_cnt = 4'h0;
                    end
                end
                USA_RX_START:
                begin
                    // a start bit gone by its centre was a glitch
                    if (tick && r_reg.rx_cnt == `USA_TICK_CENTRE)           // RULE15
                    begin
                        r_next.rx_st   = sin ? USA_RX_IDLE : USA_RX_DATA;
                        r_next.rx_cnt  = 4'h0;
                        r_next.rx_left = (nd7 ? 4'h8 : 4'h9) + {3'h0, has_x};
                    end
                end
                USA_RX_DATA:
                begin
                    if (tick && r_reg.rx_cnt == `USA_TICK_LAST)             // RULE15
                    begin
                        r_next.rx_sh   = {sin, r_reg.rx_sh[9:1]};
                        r_next.rx_left = r_reg.rx_left - 4'h1;
                        if (r_reg.rx_left == 4'h1)
                        begin
                            // only the first stop bit is looked at
                            r_next.rx_st   = USA_RX_IDLE;                   // RULE5
                            r_next.rx_left = 4'h0;
                            push_v = 1'b1;
                            push_d = {mode == `USA_MODE_MPROC && rx_x, rx_d}; // RULE7
                            if (!sin)
                                r_next.fre = 1'b1;                          // RULE11
                            if (mode == `USA_MODE_ASYNC && r_reg.ctrl[`USA_F_PAREN]
                                && (^rx_d ^ rx_x) != r_reg.ctrl[`USA_F_PARODD])
                                r_next.pe = 1'b1;                           // RULE11
                        end
                    end
                end
                default: r_next.rx_st = USA_RX_IDLE;
            endcase
        end
        // a word with nowhere to go is an overrun
        if (push_v && !rxq.in_ready)
            r_next.ore = 1'b1;                                              // RULE11
        // requests go either to the core or to the transfer service
        r_next.rx_irq = rx_req & r_reg.ctrl[`USA_F_RXIE] & ~r_reg.ctrl[`USA_F_RXIOS]; // RULE12
        r_next.rx_ios = rx_req & r_reg.ctrl[`USA_F_RXIOS];                            // RULE13
        r_next.tx_irq = ~r_reg.tx_hold_v & r_reg.ctrl[`USA_F_TXEN]
                        & r_reg.ctrl[`USA_F_TXIE] & ~r_reg.ctrl[`USA_F_TXIOS];        // RULE12
        r_next.tx_ios = ~r_reg.tx_hold_v & r_reg.ctrl[`USA_F_TXEN]
                        & r_reg.ctrl[`USA_F_TXIOS];                                   // RULE13
    end

    // state register; the line idles high
    always_ff @(posedge I_MCLK or posedge I_SYS_RST)
    begin
        if (I_SYS_RST)
        begin
            r_reg        <= '0;
            r_reg.ctrl   <= `USA_CTRL_RST;
            r_reg.waitrq <= 1'b1;
            r_reg.sin_s  <= 3'b111;
            r_reg.sck_s  <= 3'b111;
            r_reg.sout   <= 1'b1;
            r_reg.sck    <= 1'b1;
            r_reg.rx_st  <= USA_RX_IDLE;
        end
        else
        begin
            r_reg <= r_next;
        end
    end

    // every output straight from the state register
    assign O_AVS_READDATA    = r_reg.rdata;
    assign O_AVS_WAITREQUEST = r_reg.waitrq;
    assign O_SOUT            = r_reg.sout;
    assign O_SCK             = r_reg.sck;
    assign O_SCK_OE          = r_reg.sck_oe;
    assign O_RX_IRQ          = r_reg.rx_irq;
    assign O_TX_IRQ          = r_reg.tx_irq;
    assign O_RX_IOS_REQ      = r_reg.rx_ios;
    assign O_TX_IOS_REQ      = r_reg.tx_ios;
endmodule : usa_top

// ==== usa_top_props.sv ====
// usa_top_props.sv: port-level assertions for the serial port
// assumes: bound to usa_top; one clock, reset asynchronous and active high
`timescale 1ns/100ps
module usa_top_props (
    // clock and reset
    input wire logic I_MCLK,
    input wire logic I_SYS_RST,
    // bus handshake
    input wire logic I_AVS_READ,
    input wire logic I_AVS_WRITE,
    input wire logic O_AVS_WAITREQUEST,
    // line and requests
    input wire logic O_SOUT,
    input wire logic O_SCK,
    input wire logic O_SCK_OE,
    input wire logic O_RX_IRQ,
    input wire logic O_TX_IRQ,
    input wire logic O_RX_IOS_REQ,
    input wire logic O_TX_IOS_REQ
);
    default clocking cb @(posedge I_MCLK); endclocking
    default disable iff (I_SYS_RST);
    // clock low phase is eight ticks, each at least ten cycles on the internal divider
    sequence s_sck_low;
        !O_SCK [*8];
    endsequence
    // a bit lasts sixteen ticks, so eight cycles is a safe floor
    sequence s_sout_hold;
        $stable(O_SOUT) [*8];
    endsequence
    chk_ack_one_cycle: assert property (!O_AVS_WAITREQUEST |=> O_AVS_WAITREQUEST)
        else $error("waitrequest low longer than one cycle");
    chk_ack_needs_req: assert property (!O_AVS_WAITREQUEST
        |-> $past(I_AVS_READ) || $past(I_AVS_WRITE))
        else $error("answer without a request");
    chk_read_answer: assert property (I_AVS_READ && O_AVS_WAITREQUEST |=> !O_AVS_WAITREQUEST)
        else $error("read not answered next cycle");
    chk_rx_route_excl: assert property (!(O_RX_IRQ && O_RX_IOS_REQ))
        else $error("receive request on both routes");
    chk_tx_route_excl: assert property (!(O_TX_IRQ && O_TX_IOS_REQ))
        else $error("transmit request on both routes");
    chk_sck_idle_high: assert property (!O_SCK_OE |-> O_SCK)
        else $error("clock pin moves outside clocked master mode");
    chk_nrz_bit_hold: assert property ($changed(O_SOUT) && !O_SCK_OE |=> s_sout_hold)
        else $error("line level changed inside a bit");
    chk_sck_low_half: assert property ($fell(O_SCK) |=> s_sck_low)
        else $error("clock low phase too short");
    chk_data_at_rise: assert property ($rose(O_SCK) && O_SCK_OE |-> $stable(O_SOUT))
        else $error("data moved at the sampling edge");
endmodule : usa_top_props

// ==== usa_peer.sv ====
// usa_peer.sv: serial peer that loops the line back and records each byte heard
// assumes: start-stop framing at i_bit_cyc clocks per bit
`timescale 1ns/100ps
module usa_peer (
    // clock and line
    input  wire logic        i_mclk,
    input  wire logic        i_sout,
    input  wire logic [15:0] i_bit_cyc,
    // loopback and record
    output logic             o_sin,
    output logic [7:0]       o_byte
);
    // loops the transmit line straight back to the receive pin
    assign o_sin = i_sout;
    // sample at bit centres
    initial
    begin
        o_byte = 8'h00;
        forever
        begin
            @(negedge i_sout);
            repeat (i_bit_cyc / 2) @(posedge i_mclk);
            for (int i = 0; i < 8; i++)
            begin
                repeat (i_bit_cyc) @(posedge i_mclk);
                o_byte[i] = i_sout;
            end
        end
    end
endmodule : usa_peer

// ==== tb_uart_sync_async_serial.sv ====
// tb_uart_sync_async_serial.sv: register-level bench for the serial port
// assumes: usa_cfg.svh on the include path; the peer loops the line back
`timescale 1ns/100ps
`include "usa_cfg.svh"
module tb_uart_sync_async_serial;
    logic        mclk = 1'b0, tmr = 1'b0;
    logic        sys_rst = 1'b1;
    logic        avs_rd = 1'b0;
    logic        avs_wr = 1'b0;
    logic [3:0]  avs_adr = 4'h0;
    logic [31:0] avs_wd = 32'h0;
    logic [31:0] avs_rdat, q;
    logic        avs_wait, sout, sck_o, sck_oe, sck_pin, sin;
    logic        rx_irq, tx_irq, rx_ios, tx_ios;
    logic [7:0]  peer_byte;
    logic [15:0] bit_cyc = 16'h0;
    int          errors = 0;
    int          n_checks = 0;
    localparam logic [31:0] BASE = (32'h1 << `USA_F_RXEN) | (32'h1 << `USA_F_TXEN)
                                 | (32'h1 << `USA_F_RXIE);
    // rows: 8-bit, 7-bit odd parity two stops, multi-processor on timer, clocked, slower rate
    logic [31:0] t_ctl [5] = '{BASE, BASE | (32'h1 << `USA_F_LEN7) | (32'h1 << `USA_F_PAREN)
        | (32'h1 << `USA_F_PARODD) | (32'h1 << `USA_F_STOP2),
        BASE | {30'h0, `USA_MODE_MPROC} | (32'h1 << `USA_F_AD) | (32'h2 << `USA_F_CSRC),
        BASE | {30'h0, `USA_MODE_SYNC}, BASE | (32'h1 << `USA_F_BAUD)};
    logic [7:0]  t_tx [5] = '{8'hA5, 8'hD3, 8'h3C, 8'h96, 8'h5A};
    logic [8:0]  t_exp [5] = '{9'h0A5, 9'h053, 9'h13C, 9'h096, 9'h05A};
    logic [15:0] t_bit [5] = '{16'h00A0, 16'h0, 16'h0020, 16'h0, 16'h0140};
    // clock pin has a pull-up when nobody drives it
    assign sck_pin = sck_oe ? sck_o : 1'b1;
    // 20 MHz clock
    initial
    begin
        forever #25 mclk = ~mclk;
    end
    always @(posedge mclk) tmr <= ~tmr;
    usa_top dut_u (.I_MCLK(mclk), .I_SYS_RST(sys_rst), .I_AVS_ADDRESS(avs_adr),
        .I_AVS_READ(avs_rd), .I_AVS_WRITE(avs_wr), .I_AVS_WRITEDATA(avs_wd),
        .O_AVS_READDATA(avs_rdat), .O_AVS_WAITREQUEST(avs_wait), .I_SIN(sin),
        .O_SOUT(sout), .I_SCK(sck_pin), .O_SCK(sck_o), .O_SCK_OE(sck_oe),
        .I_TMR0_OUT(tmr), .O_RX_IRQ(rx_irq), .O_TX_IRQ(tx_irq),
        .O_RX_IOS_REQ(rx_ios), .O_TX_IOS_REQ(tx_ios));
    usa_peer peer_u (.i_mclk(mclk), .i_sout(sout), .i_bit_cyc(bit_cyc), .o_sin(sin),
        .o_byte(peer_byte));
    task automatic close_out();
        $display("checks %0d mismatches %0d", n_checks, errors);
        if (errors == 0 && n_checks > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask : close_out
    task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
        n_checks++;
        if (got !== exp)
        begin
            errors++;
            $display("CHECK FAILED %s expected %h seen %h", nm, exp, got);
        end
    endtask : chk
    // one bus cycle, held until waitrequest is sampled low
    task automatic bus(input logic w, input logic [3:0] a, input logic [31:0] d);
        int k;
        @(posedge mclk);
        avs_adr <= a;
        avs_wd <= d;
        avs_rd <= !w;
        avs_wr <= w;
        for (k = 0; k < 4000; k++)
        begin
            @(posedge mclk);
            if (avs_wait === 1'b0)
                break;
        end
        if (k == 4000)
        begin
            errors++;
            close_out();
        end
        q = avs_rdat;
        avs_rd <= 1'b0;
        avs_wr <= 1'b0;
    endtask : bus
    // poll status until the masked bits match
    task automatic wait_stat(input logic [31:0] m, input logic [31:0] v);
        int k;
        for (k = 0; k < 2000; k++)
        begin
            bus(1'b0, `USA_OFS_STAT, 32'h0);
            if ((q & m) === v)
                break;
        end
        if (k == 2000)
        begin
            errors++;
            close_out();
        end
    endtask : wait_stat
    initial
    begin
        repeat (20) @(posedge mclk);
        sys_rst <= 1'b0;
        bus(1'b0, `USA_OFS_CTRL, 32'h0);
        chk("ctrl reset", 32'h0, q);
        bus(1'b1, 4'h2, 32'hFFFFFFFF);
        bus(1'b0, 4'h2, 32'h0);
        chk("unmapped", 32'h0, q);
        $display("test reset done");
        for (int r = 0; r < 5; r++)
        begin
            bit_cyc = t_bit[r];
            bus(1'b1, `USA_OFS_CTRL, t_ctl[r]);
            bus(1'b1, `USA_OFS_TXD, {24'h0, t_tx[r]});
            wait_stat(32'h00000041, 32'h00000001);
            chk("rx irq", 32'h1, {31'h0, rx_irq});
            chk("rx errors", 32'h0, q & 32'h0000001C);
            bus(1'b0, `USA_OFS_RXD, 32'h0);
            chk("rxd", {23'h0, t_exp[r]}, q);
            if (t_bit[r] != 16'h0)
                chk("line", {24'h0, t_tx[r]}, {24'h0, peer_byte});
            $display("test framing %0d done", r);
        end
        // three words unread: the third finds the buffer full and is lost
        bit_cyc = 16'h0;
        bus(1'b1, `USA_OFS_CTRL, BASE | (32'h1 << `USA_F_TXIE));
        for (int r = 0; r < 3; r++)
            bus(1'b1, `USA_OFS_TXD, {24'h0, t_tx[r]});
        wait_stat(32'h00000048, 32'h00000008);
        chk("requests", 32'hC, {28'h0, rx_irq, tx_irq, rx_ios, tx_ios});
        bus(1'b1, `USA_OFS_STAT, 32'h00000008);
        bus(1'b0, `USA_OFS_STAT, 32'h0);
        chk("ore clear", 32'h1, q & 32'h00000009);
        bus(1'b1, `USA_OFS_CTRL, BASE | (32'h1 << `USA_F_TXIE) | (32'h3 << `USA_F_RXIOS));
        bus(1'b0, `USA_OFS_STAT, 32'h0);
        chk("service route", 32'h3, {28'h0, rx_irq, tx_irq, rx_ios, tx_ios});
        bus(1'b0, `USA_OFS_RXD, 32'h0);
        chk("first kept", 32'h000000A5, q);
        bus(1'b0, `USA_OFS_RXD, 32'h0);
        chk("second kept", 32'h000000D3, q);
        bus(1'b0, `USA_OFS_STAT, 32'h0);
        chk("drained", 32'h0, q & 32'h00000001);
        $display("test overrun done");
        close_out();
    end
endmodule : tb_uart_sync_async_serial

bind usa_top usa_top_props chk_u (.I_MCLK, .I_SYS_RST, .I_AVS_READ, .I_AVS_WRITE,
    .O_AVS_WAITREQUEST, .O_SOUT, .O_SCK, .O_SCK_OE, .O_RX_IRQ, .O_TX_IRQ,
    .O_RX_IOS_REQ, .O_TX_IOS_REQ);
